/* File: hw/csr_config_status.sv */
// Purpose: Read-only configuration status word and daisy output data register.
// Assumes: All inputs are synchronous to clk; requests are one-cycle pulses.
// Notes:   Parallel port wins over JTAG when both request in one cycle.
//
// How it works
// - Status word is readable over the parallel port and the JTAG port.
// - Bits 26:25 give detected bus width: 00 x1, 01 x8, 10 x16, 11 x32.
// - Parallel modes load width 01 at mode sampling, kept until detection.
// - With internal access port enabled, width shows its width after completion.
// - Bits 20:18 give the startup phase in Gray code.
// - Bit 16 flags frame data written while decryption is enabled but not active.
// - Bit 15 flags frame data written without a passed identity check.
// - Bit 13 shows the internal completion release; the done pin level does not gate it.
// - Bit 11 is one once internal initialization has finished.
// - Bits 10:8 show the three sampled mode pins.
// - Bit 6 shows the global write enable.
// - Bit 5 shows the configuration global tristate; zero means high impedance.
// - Bit 4 mirrors the end-of-startup indication.
// - Bit 3 is the AND of bank impedance matches; unused banks give one.
// - Bit 2 is the AND of clock manager locks; unused managers give one.
// - Bit 1 shows that decryptor security has been set.
// - Words written to the daisy register leave serially on the data output.
`timescale 1ns/1ns
`default_nettype none
`include "csr_map.svh"
module csr_config_status
  import csr_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Parallel configuration port.
  input  wire logic                  par_req,
  input  wire logic                  par_write,
  input  wire logic [4:0]            par_addr,
  input  wire logic [31:0]           par_wdata,
  output var  logic                  par_rvalid,
  // JTAG configuration port.
  input  wire logic                  jtag_req,
  input  wire logic                  jtag_write,
  input  wire logic [4:0]            jtag_addr,
  input  wire logic [31:0]           jtag_wdata,
  output var  logic                  jtag_rvalid,
  // Shared read data.
  output var  logic [31:0]           rdata,
  // Bus width sources.
  input  wire logic                  mode_sampled,
  input  wire logic                  parallel_mode,
  input  wire logic                  width_detect_valid,
  input  wire logic [1:0]            width_detected,
  input  wire logic                  access_port_enabled,
  input  wire logic [1:0]            access_port_width,
  input  wire logic                  config_done,
  // Startup sequencer.
  input  wire logic [2:0]            startup_phase,
  input  wire logic                  startup_finished,
  input  wire logic                  completion_released,
  input  wire logic                  init_complete,
  // Frame data checks.
  input  wire logic                  frame_data_write,
  input  wire logic                  decrypt_enabled,
  input  wire logic                  decrypt_active,
  input  wire logic                  identity_passed,
  input  wire logic                  crc_fail,
  input  wire logic                  fault_clear,
  // Pins and globals.
  input  wire logic                  done_pin,
  input  wire logic                  init_pin,
  input  wire logic [2:0]            mode_pins,
  input  wire logic                  global_high_hold,
  input  wire logic                  global_write_enable,
  input  wire logic                  config_global_tristate,
  input  wire logic                  decryptor_secured,
  input  wire logic [7:0]            bank_match,
  input  wire logic [7:0]            bank_used,
  input  wire logic [3:0]            cm_locked,
  input  wire logic [3:0]            cm_used,
  // Daisy chain.
  input  wire logic                  daisy_mode,
  output var  logic                  daisy_dout,
  output var  logic                  daisy_busy
);
  // An idle member of a group must not pull the AND low.
  function automatic logic all_ok(input logic [7:0] ok, input logic [7:0] used);
    all_ok = &(ok | ~used);
  endfunction

  function automatic logic [2:0] phase_gray(input logic [2:0] phase);
    phase_gray = phase ^ {1'b0, phase[2:1]};
  endfunction

  logic [1:0]  width_q;
  logic [1:0]  width_d;
  logic [2:0]  phase_q;
  logic        dec_fault_q;
  logic        id_fault_q;
  logic        crc_q;
  logic        done_pin_q;
  logic        init_pin_q;
  logic        release_q;
  logic        init_done_q;
  logic [2:0]  mode_q;
  logic        ghigh_q;
  logic        gwe_q;
  logic        gts_q;
  logic        eos_q;
  logic        match_q;
  logic        lock_q;
  logic        secured_q;
  logic [31:0] rdata_q;
  logic        par_rvalid_q;
  logic        jtag_rvalid_q;
  csr_word_t   status_d;
  logic        sel_req;
  logic        sel_write;
  logic [4:0]  sel_addr;
  logic [31:0] sel_wdata;
  logic        dec_set;
  logic        id_set;
  logic        hit_status;
  logic        hit_daisy;

  // The shifter keeps its own busy state, so a refused load never disturbs a word in flight.
  csr_daisy_if dsy ();

  csr_daisy_shifter u_shifter
  (
    .clk   (clk),
    .reset (reset),
    .dsy   (dsy.shifter)
  );

  // Bus width: the access port wins after completion, then detection, then mode sampling.
  always_comb
  begin
    width_d = width_q;
    if (access_port_enabled && config_done)
      width_d = access_port_width;
    else if (width_detect_valid)
      width_d = width_detected;
    else if (mode_sampled && parallel_mode)
      width_d = `CSR_WIDTH_X8;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      width_q <= `CSR_WIDTH_X1;
    else
      width_q <= width_d;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      phase_q <= 3'h0;
    else
      // Gray code lets a slow reader never see two phase bits move at once.
      phase_q <= phase_gray(startup_phase);
  end

  assign dec_set = frame_data_write && decrypt_enabled && !decrypt_active;
  assign id_set  = frame_data_write && !identity_passed;

  // Faults are sticky; a new fault in the clearing cycle is kept.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dec_fault_q <= 1'b0;
      id_fault_q  <= 1'b0;
      crc_q       <= 1'b0;
    end
    else
    begin
      if (dec_set)
        dec_fault_q <= 1'b1;
      else if (fault_clear)
        dec_fault_q <= 1'b0;
      if (id_set)
        id_fault_q <= 1'b1;
      else if (fault_clear)
        id_fault_q <= 1'b0;
      if (crc_fail)
        crc_q <= 1'b1;
      else if (fault_clear)
        crc_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      done_pin_q  <= 1'b0;
      init_pin_q  <= 1'b0;
      release_q   <= 1'b0;
      init_done_q <= 1'b0;
      mode_q      <= 3'h0;
    end
    else
    begin
      done_pin_q  <= done_pin;
      init_pin_q  <= init_pin;
      release_q   <= completion_released;
      init_done_q <= init_complete;
      mode_q      <= mode_pins;
    end
  end

  // Globals reset to their safe, configuration-time values.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ghigh_q   <= 1'b0;
      gwe_q     <= 1'b0;
      gts_q     <= 1'b0;
      eos_q     <= 1'b0;
      match_q   <= 1'b0;
      lock_q    <= 1'b0;
      secured_q <= 1'b0;
    end
    else
    begin
      ghigh_q   <= global_high_hold;
      gwe_q     <= global_write_enable;
      gts_q     <= config_global_tristate;
      eos_q     <= startup_finished;
      match_q   <= all_ok(bank_match, bank_used);
      lock_q    <= all_ok({4'h0, cm_locked}, {4'h0, cm_used});
      secured_q <= decryptor_secured;
    end
  end

  always_comb
  begin
    // Reserved and unused positions stay zero from this default.
    status_d = `CSR_WORD_ZERO;
    status_d[`CSR_WIDTH_HI:`CSR_WIDTH_LO] = width_q;
    status_d[`CSR_PHASE_HI:`CSR_PHASE_LO] = phase_q;
    status_d[`CSR_BIT_DEC_FAULT] = dec_fault_q;
    status_d[`CSR_BIT_ID_FAULT]  = id_fault_q;
    status_d[`CSR_BIT_DONE_PIN]  = done_pin_q;
    status_d[`CSR_BIT_RELEASE]   = release_q;
    status_d[`CSR_BIT_INIT_PIN]  = init_pin_q;
    status_d[`CSR_BIT_INIT_DONE] = init_done_q;
    status_d[`CSR_MODE_HI:`CSR_MODE_LO] = mode_q;
    status_d[`CSR_BIT_GHIGH]     = ghigh_q;
    status_d[`CSR_BIT_GWE]       = gwe_q;
    status_d[`CSR_BIT_GTS]       = gts_q;
    status_d[`CSR_BIT_EOS]       = eos_q;
    status_d[`CSR_BIT_IMP_MATCH] = match_q;
    status_d[`CSR_BIT_CM_LOCK]   = lock_q;
    status_d[`CSR_BIT_SECURED]   = secured_q;
    status_d[`CSR_BIT_CRC]       = crc_q;
  end

  // One port is served per cycle; a JTAG request beside a parallel one is dropped.
  always_comb
  begin
    if (par_req)
    begin
      sel_req   = 1'b1;
      sel_write = par_write;
      sel_addr  = par_addr;
      sel_wdata = par_wdata;
    end
    else
    begin
      sel_req   = jtag_req;
      sel_write = jtag_write;
      sel_addr  = jtag_addr;
      sel_wdata = jtag_wdata;
    end
  end

  // Numbers outside the map select nothing, so reads of them return zero.
  always_comb
  begin
    hit_status = 1'b0;
    hit_daisy  = 1'b0;
    if (sel_addr == `CSR_ADDR_STATUS)
      hit_status = 1'b1;
    else if (sel_addr == `CSR_ADDR_DAISY)
      hit_daisy = 1'b1;
  end

  // Read data holds until the next read, so a slow host may pick it up late.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_q       <= `CSR_WORD_ZERO;
      par_rvalid_q  <= 1'b0;
      jtag_rvalid_q <= 1'b0;
    end
    else
    begin
      par_rvalid_q  <= par_req && !par_write;
      jtag_rvalid_q <= !par_req && jtag_req && !jtag_write;
      if (sel_req && !sel_write)
      begin
        if (hit_status)
          rdata_q <= status_d;
        else
          rdata_q <= `CSR_WORD_ZERO;
      end
    end
  end

  // Daisy words only go out in daisy mode and when the shifter is free.
  assign dsy.load = sel_req && sel_write && hit_daisy && daisy_mode && !dsy.busy;
  assign dsy.word = sel_wdata;

  // A status write sets only hit_status, which no write path uses, so it changes nothing.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      daisy_dout <= 1'b0;
      daisy_busy <= 1'b0;
    end
    else
    begin
      daisy_dout <= dsy.dout;
      daisy_busy <= dsy.busy;
    end
  end

  assign rdata       = rdata_q;
  assign par_rvalid  = par_rvalid_q;
  assign jtag_rvalid = jtag_rvalid_q;
endmodule // csr_config_status
`default_nettype wire

/* File: hw/csr_daisy_if.sv */
// Purpose: Carries a daisy word from the register logic to the shifter.
// Assumes: One clock domain.
// Notes:   Load is a one-cycle pulse, taken only while busy is low.
`timescale 1ns/1ns
`default_nettype none
interface csr_daisy_if;
  logic        load;
  logic [31:0] word;
  logic        busy;
  logic        dout;
  modport regs    (output load, output word, input busy, input dout);
  modport shifter (input load, input word, output busy, output dout);
endinterface // csr_daisy_if
`default_nettype wire

/* File: hw/csr_daisy_shifter.sv */
// Purpose: Shifts a loaded daisy word out toward the next device, MSB first.
// Assumes: Daisy mode is checked by the register logic before a load.
// Notes:   A load while busy is ignored.
`timescale 1ns/1ns
`default_nettype none
`include "csr_map.svh"
module csr_daisy_shifter
  import csr_pkg::*;
(
  // Clock and reset.
  input  wire logic  clk,
  input  wire logic  reset,
  // Link to the register logic.
  csr_daisy_if.shifter dsy
);
  csr_shift_state_t state_q;
  logic [31:0]      shift_q;
  logic [4:0]       count_q;
  logic             dout_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= CSR_SH_IDLE;
      count_q <= `CSR_DAISY_FIRST;
    end
    else
    begin
      case (state_q)
        CSR_SH_IDLE:
        begin
          if (dsy.load)
          begin
            state_q <= CSR_SH_SHIFT;
            count_q <= `CSR_DAISY_FIRST;
          end
        end
        CSR_SH_SHIFT:
        begin
          if (count_q == `CSR_DAISY_LAST)
            state_q <= CSR_SH_IDLE;
          count_q <= 5'(count_q + 5'h01);
        end
        default:
          state_q <= CSR_SH_IDLE;
      endcase
    end
  end

  // Each bit stands on the serial output for one clock.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      shift_q <= `CSR_WORD_ZERO;
      dout_q  <= 1'b0;
    end
    else if (state_q == CSR_SH_IDLE && dsy.load)
    begin
      shift_q <= {dsy.word[30:0], 1'b0};
      dout_q  <= dsy.word[31];
    end
    else if (state_q == CSR_SH_SHIFT && count_q != `CSR_DAISY_LAST)
    begin
      shift_q <= {shift_q[30:0], 1'b0};
      dout_q  <= shift_q[31];
    end
  end

  assign dsy.busy = (state_q == CSR_SH_SHIFT);
  assign dsy.dout = dout_q;
endmodule // csr_daisy_shifter
`default_nettype wire

/* File: hw/csr_map.svh */
// Purpose: Named offsets, field positions, reset values and counts for the status block.
// Assumes: Register addresses are the 5-bit configuration register numbers.
// Notes:   Definitions only.
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

`define CSR_ADDR_W        5
`define CSR_ADDR_STATUS   5'h07
`define CSR_ADDR_DAISY    5'h08

`define CSR_BIT_CRC       0
`define CSR_BIT_SECURED   1
`define CSR_BIT_CM_LOCK   2
`define CSR_BIT_IMP_MATCH 3
`define CSR_BIT_EOS       4
`define CSR_BIT_GTS       5
`define CSR_BIT_GWE       6
`define CSR_BIT_GHIGH     7
`define CSR_MODE_LO       8
`define CSR_MODE_HI       10
`define CSR_BIT_INIT_DONE 11
`define CSR_BIT_INIT_PIN  12
`define CSR_BIT_RELEASE   13
`define CSR_BIT_DONE_PIN  14
`define CSR_BIT_ID_FAULT  15
`define CSR_BIT_DEC_FAULT 16
`define CSR_PHASE_LO      18
`define CSR_PHASE_HI      20
`define CSR_WIDTH_LO      25
`define CSR_WIDTH_HI      26

`define CSR_WIDTH_X1      2'h0
`define CSR_WIDTH_X8      2'h1
`define CSR_WORD_ZERO     32'h00000000
`define CSR_BANK_COUNT    8
`define CSR_CM_COUNT      4
`define CSR_DAISY_LAST    5'h1F
`define CSR_DAISY_FIRST   5'h00

`endif

/* File: hw/csr_pkg.sv */
// Purpose: Types shared by the status block and its daisy shifter.
// Assumes: Nothing is included; the state codes are plain literals.
// Notes:   Types only.
package csr_pkg;
  typedef enum logic [1:0]
  {
    CSR_SH_IDLE  = 2'h1,
    CSR_SH_SHIFT = 2'h2
  } csr_shift_state_t;
  typedef logic [31:0] csr_word_t;
endpackage

/* File: testbench/csr_config_status_assertions.sv */
// Purpose: Timing and value checks on the status block ports.
// Assumes: Status reflects inputs sampled two edges before the answer.
// Notes:   Bound to every instance of the status block.
`timescale 1ns/1ns
`default_nettype none
module csr_status_checker
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        par_req,
  input  wire logic        par_write,
  input  wire logic [4:0]  par_addr,
  input  wire logic [31:0] par_wdata,
  input  wire logic        par_rvalid,
  input  wire logic        jtag_req,
  input  wire logic        jtag_write,
  input  wire logic        jtag_rvalid,
  input  wire logic [31:0] rdata,
  input  wire logic [2:0]  startup_phase,
  input  wire logic [2:0]  mode_pins,
  input  wire logic [7:0]  bank_match,
  input  wire logic [7:0]  bank_used,
  input  wire logic        daisy_mode,
  input  wire logic        daisy_busy,
  input  wire logic        daisy_dout
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence par_rd;
    par_req && !par_write;
  endsequence
  sequence status_ans;
    par_rvalid && $past(par_addr) == 5'h07;
  endsequence
  sequence daisy_take;
    par_req && par_write && par_addr == 5'h08 && daisy_mode && !daisy_busy
      && !$past(par_req && par_write) && !$past(jtag_req && jtag_write);
  endsequence
  chk_par_answer: assert property (par_rd |=> par_rvalid)
    else $error("parallel read not answered");
  chk_jtag_answer: assert property (jtag_req && !jtag_write && !par_req |=> jtag_rvalid)
    else $error("jtag read not answered");
  chk_jtag_loses: assert property (par_req && jtag_req |=> !jtag_rvalid)
    else $error("jtag answered while parallel won");
  chk_rvalid_cause: assert property (par_rvalid |-> $past(par_req) && !$past(par_write))
    else $error("parallel answer without read");
  chk_reserved_zero: assert property (status_ans |-> rdata[31:27] == 5'h00 && rdata[24:21] == 4'h0 && !rdata[17])
    else $error("reserved status bits set");
  chk_mode_mirror: assert property (status_ans |-> rdata[10:8] == $past(mode_pins, 2))
    else $error("mode field wrong");
  chk_gray_phase: assert property (status_ans |->
    rdata[20:18] == ($past(startup_phase, 2) ^ ($past(startup_phase, 2) >> 1)))
    else $error("startup phase not gray coded");
  chk_bank_and: assert property (status_ans |-> rdata[3] == &($past(bank_match, 2) | ~$past(bank_used, 2)))
    else $error("impedance summary wrong");
  chk_daisy_first: assert property (daisy_take |-> ##2 daisy_busy && daisy_dout == $past(par_wdata[31], 2))
    else $error("daisy first bit wrong");
endmodule // csr_status_checker
bind csr_config_status csr_status_checker chk_i (.*);
`default_nettype wire

/* File: testbench/csr_daisy_catcher.sv */
// Purpose: Next device in the daisy chain, collecting the serial word.
// Assumes: One bit arrives on each clock while the busy flag is high.
// Notes:   Only catches; it never drives anything back.
`timescale 1ns/1ns
`default_nettype none
module csr_daisy_catcher
(
  // Clock.
  input  wire logic        clk,
  // Serial link.
  input  wire logic        daisy_dout,
  input  wire logic        daisy_busy,
  // Collected word.
  output var  logic [31:0] word
);
  // Shifting in MSB first puts the first bit back at the top.
  always_ff @(posedge clk)
    if (daisy_busy)
      word <= {word[30:0], daisy_dout};
endmodule // csr_daisy_catcher
`default_nettype wire

/* File: testbench/test_config_status_register.sv */
// Purpose: Register-level tests of the status word and the daisy register.
// Assumes: Inputs change at rising edges; reads answer one cycle after taken.
// Notes:   A refused daisy write must leave the link idle.
`timescale 1ns/1ns
`default_nettype none
module test_config_status_register;
  logic clk = 1'h0, reset = 1'h1;
  logic par_req = '0, par_write = '0, jtag_req = '0, jtag_write = '0;
  logic [4:0] par_addr = '0, jtag_addr = '0;
  logic [31:0] par_wdata = '0, jtag_wdata = '0, rdata, word;
  logic par_rvalid, jtag_rvalid, daisy_dout, daisy_busy, daisy_mode = '0;
  logic parallel_mode = '0, access_port_enabled = '0, config_done = '0;
  logic [1:0] width_detected = '0, access_port_width = '0;
  logic [2:0] startup_phase = '0, mode_pins = '0;
  logic decrypt_enabled = '0, decrypt_active = '0, identity_passed = '0;
  logic [7:0] bank_match = '0, bank_used = 8'hFF;
  logic [3:0] cm_locked = '0, cm_used = 4'hF;
  logic [8:0] lv = '0;
  logic [4:0] pv = '0;
  wire logic done_pin, init_pin, completion_released, init_complete, global_high_hold;
  wire logic global_write_enable, config_global_tristate, startup_finished, decryptor_secured;
  wire logic fault_clear, crc_fail, frame_data_write, width_detect_valid, mode_sampled;
  logic [2:0] gt [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};
  int pos [9] = '{1, 4, 5, 6, 7, 11, 13, 12, 14};
  int errors = 0, n_tests = 0;
  assign {done_pin, init_pin, completion_released, init_complete, global_high_hold,
          global_write_enable, config_global_tristate, startup_finished, decryptor_secured} = lv;
  assign {fault_clear, crc_fail, frame_data_write, width_detect_valid, mode_sampled} = pv;
  csr_config_status dut (.*);
  csr_daisy_catcher nxt (.clk, .daisy_dout, .daisy_busy, .word);
  always #50 clk = ~clk;
  task automatic ck(input string n, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic op(input logic p, j, w, input logic [4:0] a, input logic [31:0] v);
    @(posedge clk);
    par_req <= p;
    jtag_req <= j;
    par_write <= w;
    jtag_write <= w;
    par_addr <= a;
    jtag_addr <= a;
    par_wdata <= v;
    jtag_wdata <= v;
    @(posedge clk);
    par_req <= 1'h0;
    jtag_req <= 1'h0;
    #1;
  endtask
  // Reads the status word, checks the answer pulse and the masked bits.
  task automatic rs(input string n, input logic [31:0] m, input logic [31:0] e);
    op(1'h1, 1'h0, 1'h0, 5'h07, '0);
    ck(n, {1'h1, e}, {par_rvalid, rdata & m});
    @(posedge clk);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    pv <= 5'h01 << k;
    @(posedge clk);
    pv <= '0;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    errors++;
    close_out;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    ck("reset rdata", '0, {1'h0, rdata});
    ck("reset flags", '0, {par_rvalid, jtag_rvalid, daisy_busy, daisy_dout});
    reset <= 1'h0;
    rs("idle", 32'hFFFFFFFF, '0);
    op(1'h1, 1'h0, 1'h0, 5'h08, '0);
    ck("daisy read", 33'h100000000, {par_rvalid, rdata});
    op(1'h1, 1'h0, 1'h1, 5'h07, 32'hFFFFFFFF);
    rs("after write", 32'hFFFFFFFF, '0);
    op(1'h0, 1'h1, 1'h0, 5'h07, '0);
    ck("jtag read", 33'h100000000, {jtag_rvalid, rdata});
    op(1'h1, 1'h1, 1'h0, 5'h07, '0);
    ck("both ports", 33'h2, {par_rvalid, jtag_rvalid});
    for (int i = 0; i < 8; i++)
    begin
      startup_phase <= 3'(i);
      rs("phase", 32'h001C0000, {11'h0, gt[i], 18'h0});
    end
    for (int i = 0; i < 9; i++)
    begin
      lv <= 9'h001 << i;
      rs("level", 32'h000078F2, 32'h1 << pos[i]);
    end
    lv <= '0;
    mode_pins <= 3'h5;
    rs("mode", 32'h00000700, 32'h00000500);
    bank_used <= 8'h81;
    bank_match <= 8'h81;
    cm_used <= 4'h6;
    cm_locked <= 4'h6;
    rs("all matched", 32'h0000000C, 32'h0000000C);
    bank_match <= 8'h80;
    cm_locked <= 4'h4;
    rs("one unmatched", 32'h0000000C, '0);
    parallel_mode <= 1'h1;
    pulse(0);
    rs("width x8", 32'h06000000, 32'h02000000);
    width_detected <= 2'h3;
    pulse(1);
    rs("width x32", 32'h06000000, 32'h06000000);
    access_port_enabled <= 1'h1;
    access_port_width <= 2'h2;
    config_done <= 1'h1;
    rs("width port", 32'h06000000, 32'h04000000);
    decrypt_enabled <= 1'h1;
    pulse(2);
    rs("frame faults", 32'h00018001, 32'h00018000);
    pulse(4);
    pulse(3);
    rs("crc fault", 32'h00018001, 32'h00000001);
    pulse(4);
    decrypt_active <= 1'h1;
    identity_passed <= 1'h1;
    pulse(2);
    rs("clean frame", 32'h00018001, '0);
    daisy_mode <= 1'h1;
    op(1'h1, 1'h0, 1'h1, 5'h08, 32'hA5C30F96);
    repeat (40) @(posedge clk);
    ck("daisy word", 33'h0A5C30F96, {1'h0, word});
    daisy_mode <= 1'h0;
    op(1'h1, 1'h0, 1'h1, 5'h08, 32'h5A3CF069);
    repeat (3) @(posedge clk);
    #1;
    ck("daisy refused", 33'h0A5C30F96, {daisy_busy, word});
    close_out;
  end
endmodule // test_config_status_register
`default_nettype wire
